// File: hw/ppsc_top.sv
// Behaviour
// - wake flag sets on any wake event
// - writing one clears flag, releases pme
// - writing zero to flag does nothing
// - pme asserted only with enable set
// - two-bit power state readable and writable
// - data scale and select read zero
// - control reserved bits 7..2 read zero
// - control register survives d3hot exit reset
// - d3hot to d0 resets standard registers
// - exit reset spares vendor, pm, legacy base
// - separate registers per function at a4h..a7h
// - bridge policy enable reads one
// - disabled policy leaves secondary bus alone
// - bit 6 one: d3hot stops secondary clock
// - bridge reserved bits read zero
// - data register always reads zero
// - wake possible from d0 through d3cold
`include "ppsc_cfg.svh"

module ppsc_top (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    reset_n,
   // configuration access, one dword per cycle
   input  wire logic                    cfg_write,
   input  wire logic                    cfg_read,
   input  wire logic                    cfg_function,
   input  wire logic [7:0]              cfg_dword_addr,
   input  wire logic [3:0]              cfg_byte_enable,
   input  wire logic [31:0]             cfg_write_data,
   output logic [31:0]                  cfg_read_data,
   // wake requests from card logic, asynchronous
   input  wire logic [1:0]              wake_source,
   // wake output, open drain active low
   output logic                         pme_n_out,
   output logic                         pme_n_oe,
   // per-function state for the rest of the bridge
   output ppsc_pkg::ppsc_state_type     power_state_f0,
   output ppsc_pkg::ppsc_state_type     power_state_f1,
   output logic [1:0]                   standard_reg_reset,
   output logic [1:0]                   secondary_clock_stop,
   output logic [1:0]                   secondary_power_off
);
   import ppsc_pkg::*;

   logic [1:0]     wake_synced;
   logic [1:0]     csr_write;
   logic [1:0]     pme_drive;
   logic [1:0]     wake_flag;
   logic [1:0]     wake_enable;
   logic [1:0]     func_reset;
   logic [31:0]    csr_dword [2];
   ppsc_state_type state_of [2];
   logic [15:0]    capability_word;
   logic           cap_hit;
   logic           policy_on;
   logic           action_b2;

   // ----------------------------------------------------------------
   // wake inputs cross in through two flops
   // ----------------------------------------------------------------
   for (genvar i = 0; i < `PPSC_NUM_FUNCS; i++) begin : g_func
      ppsc_sync u_sync (
         .sys_clk  (sys_clk),
         .reset_n  (reset_n),
         .async_in (wake_source[i]),
         .sync_out (wake_synced[i])
      );

      assign csr_write[i] = cfg_write
                            && cfg_dword_addr == `PPSC_CSR_DWORD_ADDR
                            && cfg_function == 1'(i);

      ppsc_function u_func (
         .sys_clk            (sys_clk),
         .reset_n            (reset_n),
         .csr_write          (csr_write[i]),
         .byte_enable        (cfg_byte_enable),
         .write_data         (cfg_write_data),
         .wake_request       (wake_synced[i]),
         .power_state_field  (state_of[i]),
         .wake_assert_enable (wake_enable[i]),
         .wake_event_flag    (wake_flag[i]),
         .pme_drive          (pme_drive[i]),
         .function_reset     (func_reset[i]),
         .csr_dword          (csr_dword[i])
      );

      // secondary bus follows state only while policy enabled
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            secondary_clock_stop[i] <= 1'b0;
            secondary_power_off[i]  <= 1'b0;
         end else begin
            secondary_clock_stop[i] <= policy_on && action_b2
                                       && state_of[i] == ppsc_d3hot;
            secondary_power_off[i]  <= policy_on && !action_b2
                                       && state_of[i] == ppsc_d3hot;
         end
      end
   end

   localparam logic [7:0] bridge_image = `PPSC_BRIDGE_RESET;
   // fixed bits, so the secondary bus policy never moves at run time
   assign policy_on = bridge_image[`PPSC_BRIDGE_POLICY];
   assign action_b2 = bridge_image[`PPSC_BRIDGE_ACTION];

   // ----------------------------------------------------------------
   // shared capability word; only the d3cold wake bit is writable
   // ----------------------------------------------------------------
   assign cap_hit = cfg_write && cfg_byte_enable[3]
                    && cfg_dword_addr == `PPSC_CAP_DWORD_ADDR;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         capability_word <= `PPSC_CAP_RESET;
      end else if (cap_hit) begin
         capability_word[`PPSC_CAP_WAKE_D3COLD] <=
            cfg_write_data[`PPSC_CAP_WORD_LSB + `PPSC_CAP_WAKE_D3COLD];
      end
   end

   // ----------------------------------------------------------------
   // exit reset reaches only standard, legacy and socket registers;
   // pm, vendor and legacy base registers ignore it
   // ----------------------------------------------------------------
   assign standard_reg_reset = func_reset;

   // ----------------------------------------------------------------
   // read mux, registered so data comes from flops
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_read_data <= 32'h0000_0000;
      end else if (cfg_read) begin
         case (cfg_dword_addr)
            `PPSC_CSR_DWORD_ADDR: begin
               cfg_read_data <= csr_dword[cfg_function];
            end
            `PPSC_CAP_DWORD_ADDR: begin
               cfg_read_data <= {capability_word, 16'h0000};
            end
            default: begin
               cfg_read_data <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // wired wake pin: either function may pull it low
   // ----------------------------------------------------------------
   assign pme_n_out = 1'b0;
   assign pme_n_oe  = |pme_drive;

   assign power_state_f0 = state_of[0];
   assign power_state_f1 = state_of[1];
endmodule

// File: hw/ppsc_cfg.svh
`ifndef PPSC_CFG_SVH
`define PPSC_CFG_SVH

// configuration dwords holding the power-management registers
`define PPSC_CAP_DWORD_ADDR   8'ha0
`define PPSC_CSR_DWORD_ADDR   8'ha4
`define PPSC_CSR_OFFSET       8'ha4
`define PPSC_BRIDGE_OFFSET    8'ha6
`define PPSC_DATA_OFFSET      8'ha7

// control/status field positions
`define PPSC_STATE_LSB        0
`define PPSC_STATE_MSB        1
`define PPSC_ENABLE_BIT       8
`define PPSC_FLAG_BIT         15

// capability word: bit 15 writable, rest fixed
`define PPSC_CAP_RESET        16'hfe12
`define PPSC_CAP_WAKE_D3COLD  15
`define PPSC_CAP_WORD_LSB     16

// bridge extension and data readouts
`define PPSC_BRIDGE_RESET     8'hc0
`define PPSC_BRIDGE_POLICY    7
`define PPSC_BRIDGE_ACTION    6
`define PPSC_DATA_RESET       8'h00

`define PPSC_NUM_FUNCS        2

`endif

// File: hw/ppsc_pkg.sv
package ppsc_pkg;
   typedef enum logic [1:0] {
      ppsc_d0     = 2'b00,
      ppsc_d1     = 2'b01,
      ppsc_d2     = 2'b10,
      ppsc_d3hot  = 2'b11
   } ppsc_state_type;
endpackage

// File: hw/ppsc_sync.sv
module ppsc_sync (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   // level in and out
   input  wire logic async_in,
   output logic      sync_out
);
   logic stage_one;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_one <= 1'b0;
         sync_out  <= 1'b0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end
endmodule

// File: hw/ppsc_function.sv
`include "ppsc_cfg.svh"

module ppsc_function (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    reset_n,
   // configuration write to the control/status dword
   input  wire logic                    csr_write,
   input  wire logic [3:0]              byte_enable,
   input  wire logic [31:0]             write_data,
   // synchronised wake request of this function
   input  wire logic                    wake_request,
   // state out
   output ppsc_pkg::ppsc_state_type     power_state_field,
   output logic                         wake_assert_enable,
   output logic                         wake_event_flag,
   output logic                         pme_drive,
   output logic                         function_reset,
   output logic [31:0]                  csr_dword
);
   import ppsc_pkg::*;

   ppsc_state_type next_power_state;
   logic           state_write;
   logic           flag_clear;
   logic           wake_allowed;

   assign state_write = csr_write && byte_enable[0];
   assign flag_clear  = csr_write && byte_enable[1]
                        && write_data[`PPSC_FLAG_BIT];
   assign next_power_state = ppsc_state_type'(
      write_data[`PPSC_STATE_MSB:`PPSC_STATE_LSB]);
   // every D state may raise a wake
   assign wake_allowed = 1'b1;

   // ----------------------------------------------------------------
   // power state and enable; untouched by the d3hot exit reset
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         power_state_field <= ppsc_d0;
      end else if (state_write) begin
         power_state_field <= next_power_state;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_assert_enable <= 1'b0;
      end else if (csr_write && byte_enable[1]) begin
         wake_assert_enable <= write_data[`PPSC_ENABLE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // wake flag: set wins over a same-cycle clear
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_event_flag <= 1'b0;
      end else if (wake_request && wake_allowed) begin
         wake_event_flag <= 1'b1;
      end else if (flag_clear) begin
         wake_event_flag <= 1'b0;
      end
   end

   // pme follows the flag, gated by the enable
   assign pme_drive = wake_event_flag && wake_assert_enable;

   // ----------------------------------------------------------------
   // one-cycle reset pulse on d3hot to d0
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         function_reset <= 1'b0;
      end else begin
         function_reset <= state_write
                           && power_state_field == ppsc_d3hot
                           && next_power_state == ppsc_d0;
      end
   end

   // ----------------------------------------------------------------
   // read image of a4h..a7h; bridge byte reads c0h, other fixed fields read zero
   // ----------------------------------------------------------------
   always_comb begin
      csr_dword = 32'h0000_0000;
      csr_dword[`PPSC_STATE_MSB:`PPSC_STATE_LSB] = power_state_field;
      csr_dword[`PPSC_ENABLE_BIT] = wake_assert_enable;
      csr_dword[`PPSC_FLAG_BIT]   = wake_event_flag;
      csr_dword[23:16] = `PPSC_BRIDGE_RESET;
      csr_dword[31:24] = `PPSC_DATA_RESET;
   end
endmodule

// File: tb/ppsc_checker.sv
module ppsc_checker (
   // clock and reset
   input wire logic                    sys_clk,
   input wire logic                    reset_n,
   // configuration access
   input wire logic                    cfg_write,
   input wire logic                    cfg_read,
   input wire logic                    cfg_function,
   input wire logic [7:0]              cfg_dword_addr,
   input wire logic [3:0]              cfg_byte_enable,
   input wire logic [31:0]             cfg_write_data,
   input wire logic [31:0]             cfg_read_data,
   // outputs watched
   input wire logic                    pme_n_out,
   input wire logic                    pme_n_oe,
   input wire ppsc_pkg::ppsc_state_type power_state_f0,
   input wire logic [1:0]              standard_reg_reset,
   input wire logic [1:0]              secondary_clock_stop,
   input wire logic [1:0]              secondary_power_off
);
   import ppsc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   // ----
   // function 0 power checks, power-off check on both functions, then pme pin and read checks
   // ----
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire csr_rd = cfg_read && cfg_dword_addr == 8'ha4;
   sequence state_wr_s;
      cfg_write && !cfg_function && cfg_dword_addr == 8'ha4
         && cfg_byte_enable[0];
   endsequence
   sequence d3_exit_s;
      power_state_f0 == ppsc_d3hot ##1 power_state_f0 == ppsc_d0;
   endsequence
   state_write_a: assert property (state_wr_s |=>
      power_state_f0 == $past(cfg_write_data[1:0])) else $error("state");
   reset_pulse_a: assert property (d3_exit_s |->
      standard_reg_reset[0] ##1 !standard_reg_reset[0]) else $error("pulse");
   pulse_cause_a: assert property (standard_reg_reset[0] |->
      $past(power_state_f0) == ppsc_d3hot) else $error("cause");
   clock_stop_a: assert property (power_state_f0 == ppsc_d3hot [*2] |->
      secondary_clock_stop[0]) else $error("clock stop");
   clock_run_a: assert property (power_state_f0 == ppsc_d0 [*2] |->
      !secondary_clock_stop[0]) else $error("clock run");
   power_keep_a: assert property (secondary_power_off == 2'b00)
      else $error("power off");
   pme_level_a: assert property (pme_n_oe |-> !pme_n_out)
      else $error("pme level");
   bridge_read_a: assert property (csr_rd |=>
      cfg_read_data[31:16] == 16'h00c0) else $error("bridge bytes");
   resv_read_a: assert property (csr_rd |=>
      cfg_read_data[14:9] == 6'h00 && cfg_read_data[7:2] == 6'h00)
      else $error("reserved bits");
   unmapped_read_a: assert property (cfg_read
      && cfg_dword_addr != 8'ha4 && cfg_dword_addr != 8'ha0
      |=> cfg_read_data == 32'h0) else $error("unmapped");
endmodule

bind ppsc_top ppsc_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
   .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_function(cfg_function),
   .cfg_dword_addr(cfg_dword_addr), .cfg_byte_enable(cfg_byte_enable),
   .cfg_write_data(cfg_write_data), .cfg_read_data(cfg_read_data),
   .pme_n_out(pme_n_out), .pme_n_oe(pme_n_oe),
   .power_state_f0(power_state_f0), .standard_reg_reset(standard_reg_reset),
   .secondary_clock_stop(secondary_clock_stop),
   .secondary_power_off(secondary_power_off));

// File: tb/ppsc_wake_model.sv
module ppsc_wake_model (
   // card side
   input wire logic [1:0] wake_cmd,
   output wire logic [1:0] wake_source,
   // wake wire
   input wire logic       pme_n_out,
   input wire logic       pme_n_oe,
   output wire logic      pme_level
);
   timeunit 1ns;
   timeprecision 100ps;
   // card logic is unclocked, so its requests land off the edge
   assign #3 wake_source = wake_cmd;
   // pulled up: a released line reads high, not the last value
   assign pme_level = pme_n_oe ? pme_n_out : 1'b1;
endmodule

// File: tb/pci_power_state_control_tb.sv
module pci_power_state_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ppsc_pkg::*;
   `define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
      n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
      end end
   logic           sys_clk = 0, reset_n = 0, cfg_write = 0, cfg_read = 0;
   logic           cfg_function = 0, rd_p1 = 0, rd_p2 = 0;
   logic [7:0]     cfg_dword_addr = 8'h00;
   logic [3:0]     cfg_byte_enable = 4'h0;
   logic [31:0]    cfg_write_data = 32'h0, seed = 32'h94faba57, r, e;
   logic [31:0]    cfg_read_data, exp_q[$];
   logic [1:0]     wake_cmd = 2'b00, en = 2'b00, flag = 2'b00;
   logic [1:0]     st[2] = '{2'b00, 2'b00};
   logic [1:0]     wake_source, standard_reg_reset, secondary_clock_stop;
   logic           pme_n_out, pme_n_oe, pme_level;
   ppsc_state_type power_state_f0, power_state_f1;
   int             n_mismatch = 0, num_checks = 0;
   ppsc_top dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_function(cfg_function),
      .cfg_dword_addr(cfg_dword_addr), .cfg_byte_enable(cfg_byte_enable),
      .cfg_write_data(cfg_write_data), .cfg_read_data(cfg_read_data),
      .wake_source(wake_source), .pme_n_out(pme_n_out), .pme_n_oe(pme_n_oe),
      .power_state_f0(power_state_f0), .power_state_f1(power_state_f1),
      .standard_reg_reset(standard_reg_reset),
      .secondary_clock_stop(secondary_clock_stop), .secondary_power_off());
   ppsc_wake_model partner (.wake_cmd(wake_cmd), .wake_source(wake_source),
      .pme_n_out(pme_n_out), .pme_n_oe(pme_n_oe), .pme_level(pme_level));
   // ----
   // drivers, scoreboard, scenarios
   // ----
   initial forever #5 sys_clk = ~sys_clk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] csr(input logic f);
      return {16'h00c0, flag[f], 6'h00, en[f], 6'h00, st[f]};
   endfunction
   task automatic summarize();
      if (n_mismatch == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // request held over the taking edge, idle edge before the next one
   task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
      @(posedge sys_clk);
      cfg_write <= 1'b1;
      cfg_function <= f;
      cfg_dword_addr <= a;
      cfg_byte_enable <= be;
      cfg_write_data <= d;
      @(posedge sys_clk);
      cfg_write <= 1'b0;
   endtask
   task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] x);
      exp_q.push_back(x);
      @(posedge sys_clk);
      cfg_read <= 1'b1;
      cfg_function <= f;
      cfg_dword_addr <= a;
      @(posedge sys_clk);
      cfg_read <= 1'b0;
   endtask
   task automatic wait_pme(input logic lvl);
      @(negedge sys_clk);
      for (int k = 0; k < 12 && pme_level !== lvl; k++) @(negedge sys_clk);
      `CHK("pme wire", lvl, pme_level)
      if (pme_level !== lvl) summarize();
   endtask
   always @(posedge sys_clk) begin
      rd_p1 <= cfg_read;
      rd_p2 <= rd_p1;
   end
   always @(negedge sys_clk) begin
      if (rd_p2) begin
         e = exp_q.pop_front();
         `CHK("read data", e, cfg_read_data)
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int f = 0; f < 2; f++) begin
         rd(f[0], 8'ha4, csr(f[0]));
         rd(f[0], 8'ha0, 32'hfe12_0000);
      end
      wr(1'b0, 8'h40, 4'hf, 32'hffff_ffff);
      rd(1'b0, 8'h40, 32'h0);
      for (int i = 0; i < 4; i++) begin
         r = xs();
         wr(1'b0, 8'ha4, {r[20:19], 2'b11}, {r[31:9], i[0], r[7:2], i[1:0]});
         st[0] = i[1:0];
         en[0] = i[0];
         rd(1'b0, 8'ha4, csr(1'b0));
      end
      @(negedge sys_clk);
      `CHK("clock stop", 2'b01, secondary_clock_stop)
      rd(1'b1, 8'ha4, csr(1'b1));
      r = xs();
      wr(1'b0, 8'ha4, 4'b0001, {r[31:2], 2'b00});
      st[0] = 2'b00;
      @(negedge sys_clk);
      `CHK("exit pulse", 2'b01, standard_reg_reset)
      rd(1'b0, 8'ha4, csr(1'b0));
      // second function walks through d3hot and back on its own
      wr(1'b1, 8'ha4, 4'b0001, 32'h0000_0003);
      st[1] = 2'b11;
      repeat (2) @(negedge sys_clk);
      `CHK("state f1", 2'b11, power_state_f1)
      `CHK("clock stop f1", 2'b10, secondary_clock_stop)
      wr(1'b1, 8'ha4, 4'b0001, 32'h0000_0000);
      st[1] = 2'b00;
      @(negedge sys_clk);
      `CHK("exit pulse f1", 2'b10, standard_reg_reset)
      `CHK("state f1 back", 2'b00, power_state_f1)
      wake_cmd <= 2'b01;
      wait_pme(1'b0);
      wake_cmd <= 2'b00;
      flag[0] = 1'b1;
      wr(1'b0, 8'ha4, 4'b0010, 32'h0000_0100);
      rd(1'b0, 8'ha4, csr(1'b0));
      `CHK("pme held", 1'b0, pme_level)
      wr(1'b0, 8'ha4, 4'b0010, 32'h0000_8100);
      flag[0] = 1'b0;
      wait_pme(1'b1);
      wake_cmd <= 2'b10;
      repeat (6) @(posedge sys_clk);
      `CHK("pme masked", 1'b1, pme_level)
      wake_cmd <= 2'b00;
      flag[1] = 1'b1;
      rd(1'b1, 8'ha4, csr(1'b1));
      wr(1'b1, 8'ha4, 4'b0010, 32'h0000_0100);
      en[1] = 1'b1;
      wait_pme(1'b0);
      wr(1'b1, 8'ha4, 4'b0010, 32'h0000_8100);
      flag[1] = 1'b0;
      wait_pme(1'b1);
      wr(1'b0, 8'ha0, 4'hf, 32'h0);
      rd(1'b1, 8'ha0, 32'h7e12_0000);
      wr(1'b0, 8'ha0, 4'b1000, 32'hffff_ffff);
      rd(1'b0, 8'ha0, 32'hfe12_0000);
      repeat (4) @(posedge sys_clk);
      summarize();
   end
endmodule
